/* File: src/homing_method_configuration.sv */
// homing configuration: parameter registers, method decode, switch qualify, speed clip
`timescale 1ns/1ps
module homing_method_configuration (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire homing_cfg_pkg::reg_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic ack,
    output logic err,
    input wire logic [15:0] drive_control_word,
    input wire logic [15:0] max_ramp_speed,
    input wire logic reference_switch,
    input wire logic negative_limit_switch,
    input wire logic positive_limit_switch,
    input wire logic ref_move_active,
    output homing_cfg_pkg::method_t method,
    output homing_cfg_pkg::switches_t switches,
    output logic homing_start,
    output logic [15:0] search_speed_applied,
    output logic [15:0] release_speed_applied
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0] reference_switch_polarity, next_reference_switch_polarity;
    logic [15:0] negative_limit_polarity, next_negative_limit_polarity;
    logic [15:0] positive_limit_polarity, next_positive_limit_polarity;
    logic [15:0] homing_method_select, next_homing_method_select;
    logic [15:0] search_speed, next_search_speed;
    logic [15:0] release_speed, next_release_speed;
    logic [15:0] next_rdata;
    logic next_rvalid, next_ack, next_err;
    logic hit;

    // write decode with range check; out-of-range values refused
    always_comb begin
        next_reference_switch_polarity = reference_switch_polarity;
        next_negative_limit_polarity = negative_limit_polarity;
        next_positive_limit_polarity = positive_limit_polarity;
        next_homing_method_select = homing_method_select;
        next_search_speed = search_speed;
        next_release_speed = release_speed;
        next_rdata = 16'h0000;
        next_rvalid = 1'b0;
        next_ack = 1'b0;
        next_err = 1'b0;
        hit = 1'b1;
        if (req.addr == homing_cfg_pkg::ADDR_REF_POL) begin
            next_rdata = reference_switch_polarity;
            if (req.wr && req.wdata >= homing_cfg_pkg::REF_POL_MIN &&
                req.wdata <= homing_cfg_pkg::REF_POL_MAX) begin
                next_reference_switch_polarity = req.wdata;
            end else if (req.wr) begin
                next_err = 1'b1;
            end
        end else if (req.addr == homing_cfg_pkg::ADDR_NEGATIVE_LIMIT_SWITCH_POL) begin
            next_rdata = negative_limit_polarity;
            if (req.wr && req.wdata <= homing_cfg_pkg::LIM_POL_MAX) begin
                next_negative_limit_polarity = req.wdata;
            end else if (req.wr) begin
                next_err = 1'b1;
            end
        end else if (req.addr == homing_cfg_pkg::ADDR_POSITIVE_LIMIT_SWITCH_POL) begin
            next_rdata = positive_limit_polarity;
            if (req.wr && req.wdata <= homing_cfg_pkg::LIM_POL_MAX) begin
                next_positive_limit_polarity = req.wdata;
            end else if (req.wr) begin
                next_err = 1'b1;
            end
        end else if (req.addr == homing_cfg_pkg::ADDR_METHOD) begin
            next_rdata = homing_method_select;
            if (req.wr && req.wdata >= homing_cfg_pkg::METHOD_MIN &&
                req.wdata <= homing_cfg_pkg::METHOD_MAX) begin
                next_homing_method_select = req.wdata;
            end else if (req.wr) begin
                next_err = 1'b1;
            end
        end else if (req.addr == homing_cfg_pkg::ADDR_SEARCH) begin
            next_rdata = search_speed;
            if (req.wr && req.wdata >= homing_cfg_pkg::SEARCH_MIN &&
                req.wdata <= homing_cfg_pkg::SEARCH_MAX) begin
                next_search_speed = req.wdata;
            end else if (req.wr) begin
                next_err = 1'b1;
            end
        end else if (req.addr == homing_cfg_pkg::ADDR_RELEASE) begin
            next_rdata = release_speed;
            if (req.wr && req.wdata >= homing_cfg_pkg::RELEASE_MIN &&
                req.wdata <= homing_cfg_pkg::RELEASE_MAX) begin
                next_release_speed = req.wdata;
            end else if (req.wr) begin
                next_err = 1'b1;
            end
        end else begin
            hit = 1'b0;
        end
        if (req.wr || req.rd) begin
            next_ack = 1'b1;
            next_rvalid = req.rd && !req.wr && hit;
            next_err = next_err || !hit;
        end
        if (!next_rvalid) begin
            next_rdata = 16'h0000;
        end
    end

    // register storage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reference_switch_polarity <= homing_cfg_pkg::RST_REF_POL;
            negative_limit_polarity <= homing_cfg_pkg::RST_LIM_POL;
            positive_limit_polarity <= homing_cfg_pkg::RST_LIM_POL;
            homing_method_select <= homing_cfg_pkg::RST_METHOD;
            search_speed <= homing_cfg_pkg::RST_SEARCH;
            release_speed <= homing_cfg_pkg::RST_RELEASE;
            rdata <= 16'h0000;
            rvalid <= 1'b0;
            ack <= 1'b0;
            err <= 1'b0;
        end else if (clk_en) begin
            reference_switch_polarity <= next_reference_switch_polarity;
            negative_limit_polarity <= next_negative_limit_polarity;
            positive_limit_polarity <= next_positive_limit_polarity;
            homing_method_select <= next_homing_method_select;
            search_speed <= next_search_speed;
            release_speed <= next_release_speed;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            ack <= next_ack;
            err <= next_err;
        end
    end

    // ************************************************************
    // method decode
    // ************************************************************
    homing_cfg_pkg::method_t next_method;
    logic [15:0] ref_off;

    // ref codes 7..14 and 23..30 in groups of four per search direction
    always_comb begin
        next_method = '{target: homing_cfg_pkg::TGT_NEG_LIMIT, start_positive: 1'b0,
                        invert_in_switch: 1'b0, outside: 1'b0, use_index: 1'b0};
        ref_off = 16'h0000;
        case (homing_method_select)
            16'h0001: next_method.use_index = 1'b1;
            16'h0002: begin
                next_method.target = homing_cfg_pkg::TGT_POS_LIMIT;
                next_method.start_positive = 1'b1;
                next_method.use_index = 1'b1;
            end
            16'h0011: next_method.target = homing_cfg_pkg::TGT_NEG_LIMIT;
            16'h0012: begin
                next_method.target = homing_cfg_pkg::TGT_POS_LIMIT;
                next_method.start_positive = 1'b1;
            end
            16'h001f: begin
                next_method.target = homing_cfg_pkg::TGT_INDEX_ONLY;
                next_method.use_index = 1'b1; // index-only still hunts the pulse
            end
            16'h0022: begin
                next_method.target = homing_cfg_pkg::TGT_INDEX_ONLY;
                next_method.start_positive = 1'b1;
                next_method.use_index = 1'b1;
            end
            16'h0023: next_method.target = homing_cfg_pkg::TGT_SET_DIM;
            default: begin
                if (homing_method_select >= 16'h0007 && homing_method_select <= 16'h000e) begin
                    ref_off = homing_method_select - 16'h0007;
                    next_method.use_index = 1'b1;
                end else begin
                    ref_off = homing_method_select - 16'h0017;
                end
                next_method.target = homing_cfg_pkg::TGT_REF_SWITCH;
                next_method.start_positive = !ref_off[2];
                next_method.invert_in_switch = !ref_off[1];
                next_method.outside = (ref_off[1:0] == 2'b00) ||
                                      (ref_off[1:0] == 2'b11);
            end
        endcase
    end

    // ************************************************************
    // switch qualification, start trigger, speed clip
    // ************************************************************
    logic [2:0] sync1, sync2;
    logic [2:0] next_sync1;
    homing_cfg_pkg::switches_t next_switches;
    logic [15:0] next_search_applied, next_release_applied;
    logic next_start;

    // polarity, enable and clipping from synchronised levels
    always_comb begin
        next_sync1 = {reference_switch, negative_limit_switch, positive_limit_switch};
        next_switches.ref_active = ref_move_active &&
            (method.target == homing_cfg_pkg::TGT_REF_SWITCH) &&
            ((reference_switch_polarity == homing_cfg_pkg::EVAL_CLOSED) ?
             !sync2[2] : sync2[2]);
        next_switches.neg_limit_active =
            (negative_limit_polarity != homing_cfg_pkg::EVAL_OFF) &&
            ((negative_limit_polarity == homing_cfg_pkg::EVAL_CLOSED) ?
             !sync2[1] : sync2[1]);
        next_switches.pos_limit_active =
            (positive_limit_polarity != homing_cfg_pkg::EVAL_OFF) &&
            ((positive_limit_polarity == homing_cfg_pkg::EVAL_CLOSED) ?
             !sync2[0] : sync2[0]);
        next_search_applied = (search_speed > max_ramp_speed) ?
                              max_ramp_speed : search_speed;
        next_release_applied = (release_speed > max_ramp_speed) ?
                               max_ramp_speed : release_speed;
        next_start = drive_control_word[homing_cfg_pkg::CTRL_START_BIT];
    end

    // output registers and synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            method <= '{target: homing_cfg_pkg::TGT_POS_LIMIT, start_positive: 1'b1,
                        invert_in_switch: 1'b0, outside: 1'b0, use_index: 1'b0};
            switches <= '0;
            homing_start <= 1'b0;
            search_speed_applied <= 16'h0000;
            release_speed_applied <= 16'h0000;
        end else if (clk_en) begin
            sync1 <= next_sync1;
            sync2 <= sync1;
            method <= next_method;
            switches <= next_switches;
            homing_start <= next_start;
            search_speed_applied <= next_search_applied;
            release_speed_applied <= next_release_applied;
        end
    end

endmodule

/* File: include/homing_cfg_pkg.sv */
// package: constants, register map and carrier types for homing configuration
// Function
// - 16-bit method selector, codes 1..35, default 18
// - methods 1,2,17,18 home onto limit switches
// - ref+ searches start positive, ref- negative
// - inverting variants reverse direction in switch
// - outside/inside places reference beyond or within switch
// - 31/34 index only; 35 sets dimensions
// - reference switch polarity configurable, no disable
// - reference evaluation 1..2, default 1 closed
// - reference switch honoured only during reference movement
// - limit evaluation 0 off, 1 closed, 2 open
// - search speed 1..13200, default 60, clipped
// - release speed 1..3000, default 6, clipped
package homing_cfg_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] ADDR_REF_POL = 16'h061c;
    localparam logic [15:0] ADDR_NEGATIVE_LIMIT_SWITCH_POL = 16'h061e;
    localparam logic [15:0] ADDR_POSITIVE_LIMIT_SWITCH_POL = 16'h0620;
    localparam logic [15:0] ADDR_METHOD = 16'h1b18;
    localparam logic [15:0] ADDR_SEARCH = 16'h2808;
    localparam logic [15:0] ADDR_RELEASE = 16'h280a;

    // ************************************************************
    // reset values and limits
    // ************************************************************
    localparam logic [15:0] RST_REF_POL = 16'h0001;
    localparam logic [15:0] RST_LIM_POL = 16'h0001;
    localparam logic [15:0] RST_METHOD = 16'h0012;
    localparam logic [15:0] RST_SEARCH = 16'h003c;
    localparam logic [15:0] RST_RELEASE = 16'h0006;
    localparam logic [15:0] METHOD_MIN = 16'h0001;
    localparam logic [15:0] METHOD_MAX = 16'h0023;
    localparam logic [15:0] REF_POL_MIN = 16'h0001;
    localparam logic [15:0] REF_POL_MAX = 16'h0002;
    localparam logic [15:0] LIM_POL_MAX = 16'h0002;
    localparam logic [15:0] SEARCH_MIN = 16'h0001;
    localparam logic [15:0] SEARCH_MAX = 16'h3390;
    localparam logic [15:0] RELEASE_MIN = 16'h0001;
    localparam logic [15:0] RELEASE_MAX = 16'h0bb8;
    localparam logic [15:0] EVAL_OFF = 16'h0000;
    localparam logic [15:0] EVAL_CLOSED = 16'h0001;
    localparam int CTRL_START_BIT = 4;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef enum logic [2:0] {
        TGT_NEG_LIMIT, TGT_POS_LIMIT, TGT_REF_SWITCH, TGT_INDEX_ONLY, TGT_SET_DIM
    } target_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        target_t target;
        logic start_positive;
        logic invert_in_switch;
        logic outside;
        logic use_index;
    } method_t;

    typedef struct packed {
        logic ref_active;
        logic neg_limit_active;
        logic pos_limit_active;
    } switches_t;

endpackage

/* File: verification/homing_cfg_checker.sv */
// checker: port assertions for the homing configuration block
`timescale 1ns/1ps
module homing_cfg_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire homing_cfg_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic ack,
    input wire logic err,
    input wire logic [15:0] drive_control_word,
    input wire logic [15:0] max_ramp_speed,
    input wire logic ref_move_active,
    input wire homing_cfg_pkg::method_t method,
    input wire homing_cfg_pkg::switches_t switches,
    input wire logic homing_start,
    input wire logic [15:0] search_speed_applied,
    input wire logic [15:0] release_speed_applied
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // bus answers, start copy, clipping, gating and limit decode
    a_ack_after_req: assert property (clk_en && (req.wr || req.rd) |=> ack)
        else $error("no ack after request");
    a_err_with_ack: assert property (err |-> ack)
        else $error("err without ack");
    a_rvalid_clean: assert property (rvalid |-> ack && !err)
        else $error("rvalid with err or no ack");
    a_rdata_idle_zero: assert property (!rvalid |-> rdata == 16'h0000)
        else $error("rdata not zero when idle");
    a_start_copy: assert property (clk_en |=> homing_start == $past(drive_control_word[4]))
        else $error("start does not follow bit 4");
    a_search_clip: assert property (clk_en |=> search_speed_applied <= $past(max_ramp_speed))
        else $error("search speed above limit");
    a_release_clip: assert property (clk_en |=> release_speed_applied <= $past(max_ramp_speed))
        else $error("release speed above limit");
    a_ref_gated: assert property (switches.ref_active |-> $past(ref_move_active) ||
        $past(ref_move_active, 2) || $past(ref_move_active, 3))
        else $error("reference switch honoured outside movement");
    a_limit_direction: assert property (method.target == homing_cfg_pkg::TGT_NEG_LIMIT
        |-> !method.start_positive)
        else $error("negative limit method starts positive");
endmodule

bind homing_method_configuration homing_cfg_checker u_chk (.clk_sys, .rst, .clk_en, .req,
    .rdata, .rvalid, .ack, .err, .drive_control_word, .max_ramp_speed, .ref_move_active,
    .method, .switches, .homing_start, .search_speed_applied, .release_speed_applied);

/* File: verification/axis_partner.sv */
// partner: switch contacts and start request from outside the drive
`timescale 1ns/1ps
module axis_partner (
    input wire logic [2:0] actuated,
    input wire logic [2:0] normally_open,
    input wire logic start_request,
    output logic [2:0] contacts,
    output logic [15:0] control_word
);
    // closed-type contact opens when actuated, open-type closes
    assign contacts = actuated ^ ~normally_open;
    // start request travels in bit 4 only
    assign control_word = {11'h000, start_request, 4'h0};
endmodule

/* File: verification/homing_method_configuration_tb.sv */
// testbench: register access, method decode, switches and speeds
`timescale 1ns/1ps
module homing_method_configuration_tb;
    logic clk_sys, rst, clk_en, ref_move_active, start_request, rvalid, ack, err, homing_start;
    logic [15:0] rdata, max_ramp_speed, control_word, search_speed_applied, release_speed_applied;
    logic [15:0] rd_val, rd_err, rd_ok;
    logic [2:0] actuated, normally_open, contacts;
    homing_cfg_pkg::reg_req_t req;
    homing_cfg_pkg::method_t method, em;
    homing_cfg_pkg::switches_t switches;
    int errors = 0, total_checks = 0, cycles = 0;
    logic [31:0] defs[6] = '{32'h061c_0001, 32'h061e_0001, 32'h0620_0001, 32'h1b18_0012,
        32'h2808_003c, 32'h280a_0006};
    logic [47:0] bad[9] = '{48'h061c_0000_0001, 48'h061c_0003_0001, 48'h061e_0003_0001,
        48'h0620_0003_0001, 48'h1b18_0000_0012, 48'h1b18_0024_0012, 48'h2808_0000_003c,
        48'h2808_3391_003c, 48'h280a_0bb9_0006};
    int codes[17] = '{1, 2, 17, 18, 8, 13, 23, 24, 25, 26, 27, 28, 29, 30, 31, 34, 35};
    homing_method_configuration DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .req(req),
        .rdata(rdata), .rvalid(rvalid), .ack(ack), .err(err), .drive_control_word(control_word),
        .max_ramp_speed(max_ramp_speed), .reference_switch(contacts[2]),
        .negative_limit_switch(contacts[1]), .positive_limit_switch(contacts[0]),
        .ref_move_active(ref_move_active), .method(method), .switches(switches),
        .homing_start(homing_start), .search_speed_applied(search_speed_applied),
        .release_speed_applied(release_speed_applied));
    axis_partner partner (.actuated(actuated), .normally_open(normally_open),
        .start_request(start_request), .contacts(contacts), .control_word(control_word));
    // clock and hang limit
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // one register access, answer sampled the cycle after it is taken
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
        req = '{addr: addr, wdata: data, wr: wr, rd: !wr};
        step(1);
        req = '0;
        rd_val = rdata;
        rd_err = {15'h0, err};
        rd_ok = {15'h0, rvalid};
        check({15'h0, ack}, 16'h0001);
        step(1);
    endtask
    // main sequence
    initial begin
        clk_en = 1;
        rst = 1;
        req = '0;
        max_ramp_speed = 16'h1388;
        ref_move_active = 0;
        start_request = 0;
        actuated = 3'h0;
        normally_open = 3'h0;
        step(6);
        rst = 0;
        foreach (defs[i]) begin
            access(0, defs[i][31:16], 16'h0000);
            check(rd_val, defs[i][15:0]);
            check(rd_ok, 16'h0001);
        end
        access(0, 16'h0622, 16'h0000);
        check(rd_err | rd_val, 16'h0001);
        check(rd_val, 16'h0000);
        check(rd_ok, 16'h0000);
        foreach (bad[i]) begin
            access(1, bad[i][47:32], bad[i][31:16]);
            check(rd_err, 16'h0001);
            check(rd_ok, 16'h0000);
            access(0, bad[i][47:32], 16'h0000);
            check(rd_val, bad[i][15:0]);
        end
        max_ramp_speed = 16'h03e8;
        access(1, 16'h2808, 16'h3390);
        access(1, 16'h280a, 16'h0bb8);
        check(search_speed_applied, 16'h03e8);
        check(release_speed_applied, 16'h03e8);
        max_ramp_speed = 16'h1388;
        step(2);
        check(search_speed_applied, 16'h1388);
        check(release_speed_applied, 16'h0bb8);
        foreach (codes[i]) begin
            access(1, 16'h1b18, codes[i][15:0]);
            step(1);
            em = '0;
            em.target = homing_cfg_pkg::TGT_REF_SWITCH;
            em.use_index = codes[i] < 17 || codes[i] > 30;
            em.start_positive = (codes[i] - 7) % 16 < 4 || codes[i] == 2 || codes[i] == 18;
            em.invert_in_switch = (codes[i] - 7) % 4 < 2;
            em.outside = (codes[i] - 7) % 4 == 0 || (codes[i] - 7) % 4 == 3;
            if (codes[i] == 1 || codes[i] == 17) begin
                em.target = homing_cfg_pkg::TGT_NEG_LIMIT;
                em.start_positive = 1'b0;
            end else if (codes[i] == 2 || codes[i] == 18) begin
                em.target = homing_cfg_pkg::TGT_POS_LIMIT;
            end else if (codes[i] > 30) begin
                em.target = codes[i] == 35 ? homing_cfg_pkg::TGT_SET_DIM :
                    homing_cfg_pkg::TGT_INDEX_ONLY;
                em.start_positive = codes[i] == 34;
            end
            check({13'h0, method.target}, {13'h0, em.target});
            if (codes[i] != 35) begin
                check({14'h0, method.start_positive, method.use_index},
                    {14'h0, em.start_positive, em.use_index});
            end
            if (em.target == homing_cfg_pkg::TGT_REF_SWITCH) begin
                check({14'h0, method.invert_in_switch, method.outside},
                    {14'h0, em.invert_in_switch, em.outside});
            end
        end
        actuated = 3'h3;
        step(4);
        check({13'h0, switches}, 16'h0003);
        access(1, 16'h061e, 16'h0000);
        access(1, 16'h0620, 16'h0002);
        normally_open = 3'h1;
        step(4);
        check({13'h0, switches}, 16'h0001);
        access(1, 16'h1b18, 16'h001b);
        actuated = 3'h4;
        step(4);
        check({13'h0, switches}, 16'h0000);
        ref_move_active = 1;
        step(5);
        check({13'h0, switches}, 16'h0004);
        access(1, 16'h061c, 16'h0002);
        step(4);
        check({13'h0, switches}, 16'h0000);
        start_request = 1;
        step(2);
        check({15'h0, homing_start}, 16'h0001);
        clk_en = 0;
        start_request = 0;
        step(3);
        check({15'h0, homing_start}, 16'h0001);
        clk_en = 1;
        step(2);
        check({15'h0, homing_start}, 16'h0000);
        stop_test();
    end
endmodule
